// ### bench/sild_host_model.sv
// Host model that shifts bits into the driver at a chosen rate
module sild_host_model (
    input wire logic clk,
    output logic o_sdata,
    output logic o_sclk
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_sdata = 1'b0;
        o_sclk = 1'b0;
    end
    // Sends w[n-1] first; half is the clock phase length in cycles
    task automatic send(input logic [19:0] w, input int half, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            o_sdata = w[i];
            repeat (half) @(negedge clk);
            o_sclk = 1'b1;
            repeat (half) @(negedge clk);
            o_sclk = 1'b0;
        end
        // Data is not held past its hold time, so show its inverse
        o_sdata = ~o_sdata;
    endtask : send
endmodule : sild_host_model

// ### bench/sild_props.sv
// Port checks for the serial-in latched driver
module sild_props #(
    parameter int STAGES = 20
) (
    // ==========================================================
    // Clock, reset and host pins
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_SCLK,
    input wire logic I_LOAD,
    input wire logic I_BLANK,
    // ==========================================================
    // Outputs
    input wire logic O_SDATA,
    input wire logic [STAGES-1:0] O_SRC_EN,
    input wire logic [STAGES-1:0] O_PULLDN_EN,
    input wire logic O_RATE_ERR
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);
    logic sclk_reg;
    logic [3:0] age_reg;
    always_ff @(posedge I_MCLK) begin
        sclk_reg <= I_SCLK;
    end
    // Cycles since the shift clock pin last rose, saturating
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            age_reg <= 4'hF;
        end else if (I_SCLK && !sclk_reg) begin
            age_reg <= 4'h0;
        end else if (age_reg != 4'hF) begin
            age_reg <= age_reg + 4'h1;
        end
    end
    chk_pulldn_inverse: assert property (O_PULLDN_EN == ~O_SRC_EN)
        else $error("pull-down is not the inverse of source");
    chk_blank_off: assert property (I_BLANK [*6] |-> O_SRC_EN == '0)
        else $error("source on while blanked");
    chk_shift_hold: assert property ((!I_SCLK) [*8] |=>
        $stable(O_SDATA))
        else $error("serial output moved without a shift edge");
    chk_latch_hold: assert property ((!I_LOAD && !I_BLANK) [*8] |=>
        $stable(O_SRC_EN)) else $error("latch changed with load low");
    chk_load_follow: assert property (
        (I_LOAD && !I_BLANK && !I_SCLK) [*8]
        |-> O_SRC_EN[STAGES-1] == O_SDATA) else $error("last output off");
    chk_sdata_cause: assert property ($changed(O_SDATA) |->
        age_reg <= 4'hC) else $error("serial output moved late");
    chk_rate_sticky: assert property (O_RATE_ERR |=> O_RATE_ERR)
        else $error("rate flag dropped");
    chk_reset_clear: assert property ($fell(I_RST) |-> O_SRC_EN == '0
        && !O_SDATA && !O_RATE_ERR) else $error("bad reset state");
    cover property (I_BLANK [*6]);
    cover property ($rose(O_RATE_ERR));
    cover property ((I_LOAD && !I_BLANK) [*8]);
endmodule : sild_props

bind sild_top sild_props #(.STAGES(STAGES)) u_props (
    .I_MCLK(I_MCLK), .I_RST(I_RST), .I_SCLK(I_SCLK), .I_LOAD(I_LOAD),
    .I_BLANK(I_BLANK), .O_SDATA(O_SDATA), .O_SRC_EN(O_SRC_EN),
    .O_PULLDN_EN(O_PULLDN_EN), .O_RATE_ERR(O_RATE_ERR)
);

// ### bench/test_sild_top.sv
// Self-checking bench for the serial-in latched driver
module test_sild_top
    import sild_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = 20;
    logic mclk, rst, ld, blank, sdata, sclk, so, rdy, rerr;
    logic smp = 1'b0;
    sild_word_t src, pdn, w, v;
    logic [N+2:0] exp_q[$];
    logic [31:0] lfsr = 32'h775847B8;
    int err_count = 0;
    int n_compared = 0;
    sild_top i_dut (.I_MCLK(mclk), .I_RST(rst), .I_SDATA(sdata),
        .I_SCLK(sclk), .I_LOAD(ld), .I_BLANK(blank), .O_SDATA(so),
        .O_SRC_EN(src), .O_PULLDN_EN(pdn), .O_IN_READY(rdy),
        .O_RATE_ERR(rerr));
    sild_host_model u_host (.clk(mclk), .o_sdata(sdata), .o_sclk(sclk));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    task automatic give_verdict();
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic expect_out(input sild_word_t s, input logic o,
        input logic e);
        exp_q.push_back({1'b1, e, o, s});
        smp = 1'b1;
        @(negedge mclk);
        smp = 1'b0;
    endtask : expect_out
    // ==========================================================
    // Monitor: compares outputs with the oldest note
    always @(posedge mclk) begin
        if (smp === 1'b1) begin
            logic [N+2:0] e;
            e = exp_q.pop_front();
            n_compared++;
            if ({rdy, rerr, so, src} !== e || pdn !== ~e[N-1:0]) begin
                err_count++;
                $display("CHECK FAILED %0t got %h want %h", $time,
                    {rdy, rerr, so, src}, e);
            end
        end
    end
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        give_verdict();
    end
    // ==========================================================
    // Stimulus
    initial begin
        rst = 1'b1;
        ld = 1'b0;
        blank = 1'b0;
        v = '0;
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        expect_out('0, 1'b0, 1'b0);
        for (int k = 0; k < 3; k++) begin
            lfsr = lfsr_next(lfsr);
            w = lfsr[N-1:0];
            u_host.send(w, 7, N);
            repeat (12) @(negedge mclk);
            expect_out(v, w[N-1], 1'b0);
            ld = 1'b1;
            repeat (8) @(negedge mclk);
            ld = 1'b0;
            repeat (8) @(negedge mclk);
            expect_out(w, w[N-1], 1'b0);
            blank = 1'b1;
            repeat (8) @(negedge mclk);
            expect_out('0, w[N-1], 1'b0);
            ld = 1'b1;
            u_host.send({19'h00000, lfsr[N]}, 7, 1);
            repeat (12) @(negedge mclk);
            expect_out('0, w[N-2], 1'b0);
            ld = 1'b0;
            repeat (8) @(negedge mclk);
            blank = 1'b0;
            repeat (8) @(negedge mclk);
            v = {w[N-2:0], lfsr[N]};
            expect_out(v, w[N-2], 1'b0);
        end
        // Shift edges closer than allowed are flagged yet still shifted
        lfsr = lfsr_next(lfsr);
        w = lfsr[N-1:0];
        u_host.send(w, 4, N);
        repeat (12) @(negedge mclk);
        ld = 1'b1;
        repeat (8) @(negedge mclk);
        expect_out(w, w[N-1], 1'b1);
        repeat (4) @(negedge mclk);
        give_verdict();
    end
endmodule : test_sild_top

// ### rtl/sild_fifo.sv
// Bit buffer between the captured shift edges and the shift engine
module sild_fifo #(
    parameter int W = 1,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic i_wr_valid,
    input wire logic [W-1:0] i_wr_data,
    output logic o_wr_ready,
    // Drain side
    sild_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    logic push;
    logic pop;

    assign o_wr_ready = (count_reg != FULL);
    assign rd.valid = (count_reg != '0);
    assign rd.data = mem[rd_ptr_reg];
    assign push = i_wr_valid && o_wr_ready;
    assign pop = rd.valid && rd.ready;

    // ======================================================
    // Storage has no reset; only the pointers and the count define content
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0
                              : wr_ptr_reg + AW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0
                              : rd_ptr_reg + AW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + CW'(1);
        end else if (pop && !push) begin
            count_reg <= count_reg - CW'(1);
        end
    end
endmodule : sild_fifo

// ### rtl/sild_params.svh
// Constants of the serial-in latched driver: sizes, resets, timing counts
`ifndef SILD_PARAMS_SVH
`define SILD_PARAMS_SVH

// ==========================================================
// Structure
`define SILD_STAGES 20
`define SILD_FIFO_DEPTH 32
`define SILD_FIFO_WIDTH 1
`define SILD_SYNC_WIDTH 4

// ==========================================================
// Pin positions inside the synchroniser word
`define SILD_PIN_SDATA 0
`define SILD_PIN_SCLK 1
`define SILD_PIN_LOAD 2
`define SILD_PIN_BLANK 3

// ==========================================================
// Reset values
`define SILD_RST_STAGES 20'h00000
`define SILD_RST_PINS 4'h0

// ==========================================================
// Timing: clock rate and the fastest legal shift clock, in Hz
`define SILD_CLK_HZ 40000000
`define SILD_MAX_SHIFT_HZ 3300000
// Least cycles between two shift edges, rounded up
`define SILD_MIN_SHIFT_CYC \
    ((`SILD_CLK_HZ + `SILD_MAX_SHIFT_HZ - 1) / `SILD_MAX_SHIFT_HZ)

`endif

// ### rtl/sild_pkg.sv
// Types shared by the serial-in latched driver modules
`include "sild_params.svh"

package sild_pkg;

    // ======================================================
    // Shift engine states
    typedef enum logic [0:0] {
        SILD_ST_IDLE = 1'b0,
        SILD_ST_SETTLE = 1'b1
    } sild_eng_e;

    // ======================================================
    // Parallel word, one bit per stage
    typedef logic [`SILD_STAGES-1:0] sild_word_t;

endpackage : sild_pkg

// ### rtl/sild_stream_if.sv
// Valid/ready stream between the bit buffer and the shift engine
interface sild_stream_if #(
    parameter int W = 1
) (
    input wire logic clk
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sild_stream_if

// ### rtl/sild_sync.sv
// Three-stage pin synchroniser with agreement filter
`include "sild_params.svh"

module sild_sync #(
    parameter int W = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins and filtered levels
    input wire logic [W-1:0] i_pin,
    output logic [W-1:0] o_level
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // ======================================================
    // Stage one feeds stage two only
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
        end else begin
            s1_reg <= i_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // ======================================================
    // A new level counts once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_ff @(posedge clk) begin
                if (rst) begin
                    o_level[g] <= RST_VAL[g];
                end else if (s2_reg[g] == s3_reg[g]) begin
                    o_level[g] <= s3_reg[g];
                end
            end
        end
    endgenerate
endmodule : sild_sync

// ### rtl/sild_top.sv
// Serial-in latched driver: shift stages, output latches and blanking
`include "sild_params.svh"

// Function
// RULE1 - A rising shift clock captures the data input into stage one.
// RULE2 - Each later rising edge moves every bit one stage onward; else hold.
// RULE3 - Host sets the data bit before raising the shift clock.
// RULE4 - Load high makes latches follow the stages; load low holds them.
// RULE5 - With load tied high the host keeps blanking high while shifting.
// RULE6 - Blanking high turns every source off and every pull-down on.
// RULE7 - Blanking never alters what the latches hold.
// RULE8 - Blanking low drives each output from its own latch.
// RULE9 - Host keeps the shift clock at or below 3.3 MHz.
// RULE10 - Twenty stages, twenty latches, twenty outputs.
// RULE11 - The serial output always shows the last stage.
module sild_top
    import sild_pkg::*;
#(
    parameter int STAGES = `SILD_STAGES,
    parameter int FIFO_DEPTH = `SILD_FIFO_DEPTH,
    parameter int MIN_SHIFT_CYC = `SILD_MIN_SHIFT_CYC
) (
    // Clock and reset
    input wire logic I_MCLK,
    input wire logic I_RST,
    // Host pins
    input wire logic I_SDATA,
    input wire logic I_SCLK,
    input wire logic I_LOAD,
    input wire logic I_BLANK,
    // Cascade output
    output logic O_SDATA,
    // Driver controls, one bit per output
    output logic [STAGES-1:0] O_SRC_EN,
    output logic [STAGES-1:0] O_PULLDN_EN,
    // Status
    output logic O_IN_READY,
    output logic O_RATE_ERR
);
    localparam int RCW = $clog2(MIN_SHIFT_CYC + 1);
    localparam logic [RCW-1:0] RATE_MIN = RCW'(MIN_SHIFT_CYC);

    logic [`SILD_SYNC_WIDTH-1:0] pins;
    logic [`SILD_SYNC_WIDTH-1:0] lvl;
    logic sclk_d_reg;
    logic sclk_rise;
    logic wr_ready;
    logic [STAGES-1:0] shift_reg;
    logic [STAGES-1:0] latch_reg;
    logic [RCW-1:0] gap_reg;
    logic rate_err_reg;
    logic in_ready_reg;
    sild_eng_e eng_reg;
    sild_eng_e eng_next;

    sild_stream_if #(.W(`SILD_FIFO_WIDTH)) bits (.clk(I_MCLK));

    // ======================================================
    // Pin capture
    assign pins = {I_BLANK, I_LOAD, I_SCLK, I_SDATA};

    sild_sync #(
        .W(`SILD_SYNC_WIDTH),
        .RST_VAL(`SILD_RST_PINS)
    ) u_sync (
        .clk(I_MCLK),
        .rst(I_RST),
        .i_pin(pins),
        .o_level(lvl)
    );

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            sclk_d_reg <= 1'b0;
        end else begin
            sclk_d_reg <= lvl[`SILD_PIN_SCLK];
        end
    end

    // Data passes the same filter as the clock, so a bit set up
    // before the edge is still the one seen with it
    assign sclk_rise = lvl[`SILD_PIN_SCLK] && !sclk_d_reg; // RULE1

    // ======================================================
    // Edge buffer: absorbs edges while the engine settles
    sild_fifo #(
        .W(`SILD_FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(I_MCLK),
        .rst(I_RST),
        .i_wr_valid(sclk_rise),
        .i_wr_data(lvl[`SILD_PIN_SDATA]),
        .o_wr_ready(wr_ready),
        .rd(bits.src)
    );

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            in_ready_reg <= 1'b0;
        end else begin
            in_ready_reg <= wr_ready;
        end
    end

    // ======================================================
    // Shift engine: one shift, then one settle cycle so the
    // latches see every intermediate word while load is high
    always_comb begin
        eng_next = eng_reg;
        case (eng_reg)
            SILD_ST_IDLE: begin
                if (bits.valid) begin
                    eng_next = SILD_ST_SETTLE;
                end
            end
            SILD_ST_SETTLE: begin
                eng_next = SILD_ST_IDLE;
            end
            default: begin
                eng_next = SILD_ST_IDLE;
            end
        endcase
    end

    assign bits.ready = (eng_reg == SILD_ST_IDLE);

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            eng_reg <= SILD_ST_IDLE;
        end else begin
            eng_reg <= eng_next;
        end
    end

    // ======================================================
    // Shift stages; stage one is bit 0
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            shift_reg <= `SILD_RST_STAGES; // RULE10
        end else if (bits.valid && bits.ready) begin
            shift_reg <= {shift_reg[STAGES-2:0], bits.data[0]}; // RULE2
        end
    end

    // ======================================================
    // Latches: transparent on load, blind to blanking
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            latch_reg <= `SILD_RST_STAGES;
        end else if (lvl[`SILD_PIN_LOAD]) begin
            latch_reg <= shift_reg; // RULE4 RULE7
        end
    end

    // ======================================================
    // Output drive
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_SRC_EN <= '0;
            O_PULLDN_EN <= '1;
        end else if (lvl[`SILD_PIN_BLANK]) begin
            O_SRC_EN <= '0; // RULE6
            O_PULLDN_EN <= '1; // RULE6
        end else begin
            O_SRC_EN <= latch_reg; // RULE8
            O_PULLDN_EN <= ~latch_reg; // RULE8
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            O_SDATA <= 1'b0;
        end else begin
            O_SDATA <= shift_reg[STAGES-1]; // RULE11
        end
    end

    // ======================================================
    // Shift rate watch: edges closer than the legal period are
    // flagged, since the host, not this block, paces the clock
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            gap_reg <= RATE_MIN;
        end else if (sclk_rise) begin
            gap_reg <= RCW'(1);
        end else if (gap_reg != RATE_MIN) begin
            gap_reg <= gap_reg + RCW'(1);
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            rate_err_reg <= 1'b0;
        end else if (sclk_rise && gap_reg < RATE_MIN) begin
            rate_err_reg <= 1'b1; // RULE9
        end
    end

    assign O_IN_READY = in_ready_reg;
    assign O_RATE_ERR = rate_err_reg;
endmodule : sild_top
